// [logic/capture_timer_pkg.sv]
// Constants shared by the input capture timer design
package capture_timer_pkg;

   // ***************************************************
   // Register byte addresses (index times four)
   // ***************************************************
   localparam logic [7:0]  IDX_CAPTURE_VALUE_F = 8'hBD;
   localparam logic [7:0]  IDX_CONTROL         = 8'hBC;
   localparam logic [7:0]  IDX_CAPTURE_VALUE_R = 8'hBE;
   localparam logic [7:0]  IDX_COUNT           = 8'hBF;
   localparam logic [11:0] ADDR_CAPTURE_VALUE_F = {2'h0, IDX_CAPTURE_VALUE_F, 2'h0};
   localparam logic [11:0] ADDR_CONTROL         = {2'h0, IDX_CONTROL, 2'h0};
   localparam logic [11:0] ADDR_CAPTURE_VALUE_R = {2'h0, IDX_CAPTURE_VALUE_R, 2'h0};
   localparam logic [11:0] ADDR_COUNT           = {2'h0, IDX_COUNT, 2'h0};

   // ***************************************************
   // Control register fields
   // ***************************************************
   localparam int BIT_OVF_HIGH    = 7;
   localparam int BIT_OVF_LOW     = 6;
   localparam int BIT_OVF_IRQ_EN  = 5;
   localparam int BIT_EDGE_SELECT = 4;
   localparam int POS_CLEAR_SEL   = 2;
   localparam int POS_CLOCK_SEL   = 0;

   // ***************************************************
   // Reset values and encodings
   // ***************************************************
   localparam logic [7:0] RESET_CONTROL = 8'h00;
   localparam logic [7:0] RESET_CAPTURE = 8'h00;
   localparam logic [7:0] COUNT_MAX     = 8'hFF;
   localparam logic [1:0] CLEAR_NONE    = 2'h0;
   localparam logic [1:0] CLEAR_FALL    = 2'h1;
   localparam logic [1:0] CLEAR_RISE    = 2'h2;
   localparam logic [1:0] CLEAR_BOTH    = 2'h3;
   localparam logic [1:0] CLK_DIV64     = 2'h0;
   localparam logic [1:0] CLK_DIV32     = 2'h1;
   localparam logic [1:0] CLK_DIV2      = 2'h2;
   localparam logic [1:0] CLK_SUB_DIV2  = 2'h3;
   localparam logic [5:0] MASK_DIV64    = 6'h3F;
   localparam logic [5:0] MASK_DIV32    = 6'h1F;
   localparam logic [5:0] MASK_DIV2     = 6'h01;

   // ***************************************************
   // Bus transfer type and size codes
   // ***************************************************
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HSIZE_WORD    = 2'h2;

endpackage : capture_timer_pkg

// [logic/capture_prescaler.sv]
// Prescaler producing one-cycle count ticks
`timescale 1ns/1ps
module capture_prescaler (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // Selection and subclock
   input  wire logic [1:0] clock_select,
   input  wire logic       subclock_tick,
   // Tick out
   output logic            count_tick
);

   logic [5:0] div_q;
   logic       sub_q;
   logic [5:0] mask;
   logic       sys_tick;
   logic       sub_tick;

   // Mask for system clock division
   assign mask = (clock_select == capture_timer_pkg::CLK_DIV64) ? capture_timer_pkg::MASK_DIV64 :
                 (clock_select == capture_timer_pkg::CLK_DIV32) ? capture_timer_pkg::MASK_DIV32 :
                 capture_timer_pkg::MASK_DIV2;
   assign sys_tick   = ((div_q & mask) == mask);
   assign sub_tick   = subclock_tick & sub_q;
   assign count_tick = (clock_select == capture_timer_pkg::CLK_SUB_DIV2) ? sub_tick : sys_tick;

   // Free running divider and subclock halver
   always_ff @(posedge core_clk) begin
      if (rst) begin
         div_q <= 6'h00;
         sub_q <= 1'b0;
      end else begin
         div_q <= div_q + 6'h01;
         if (subclock_tick) begin
            sub_q <= ~sub_q;
         end
      end
   end

endmodule : capture_prescaler

// [logic/input_capture_timer_8bit.sv]
// Eight-bit up counter with input capture and AHB-Lite registers
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
module input_capture_timer_8bit (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Capture input and subclock
   input  wire logic        capture_in,
   input  wire logic        subclock_tick,
   // Overflow interrupt request
   output logic             overflow_irq
);

   // ***************************************************
   // State
   // ***************************************************
   logic       overflow_flag_high_q;
   logic       overflow_flag_low_q;
   logic       overflow_irq_enable_q;
   logic       capture_irq_edge_select_q;
   logic [1:0] counter_clear_select_q;
   logic [1:0] clock_select_q;
   logic [7:0] capture_timer_count_q;
   logic [7:0] capture_value_f_q;
   logic [7:0] capture_value_r_q;
   logic       capture_prev_q;
   // Set when software has read the flag as one, armed for a clearing write
   logic       seen_high_q;
   logic       seen_low_q;
   logic       overflow_irq_q;
   // Write data phase pending and the address it was taken at
   logic       wr_pend_q;
   logic [11:0] addr_q;
   logic [31:0] hrdata_q;

   // ***************************************************
   // Decode
   // ***************************************************
   logic       access;
   logic       wr_ctrl;
   logic       rd_ctrl;
   logic       count_tick;
   logic       wrap;
   logic       rise;
   logic       fall;
   logic       clear_cnt;
   logic [7:0] ctrl_value;
   logic [7:0] rd_value;
   logic       clr_high;
   logic       clr_low;

   // Transfer taken in its address phase; a write lands one cycle later with hwdata
   // Size is not checked: every register is one aligned word in the low byte
   assign access  = hsel & hready & (htrans == capture_timer_pkg::HTRANS_NONSEQ);
   assign wr_ctrl = wr_pend_q & (addr_q == capture_timer_pkg::ADDR_CONTROL);
   assign rd_ctrl = access & ~hwrite & (haddr == capture_timer_pkg::ADDR_CONTROL);

   // Control register as software sees it
   assign ctrl_value = {overflow_flag_high_q, overflow_flag_low_q, overflow_irq_enable_q,
                        capture_irq_edge_select_q, counter_clear_select_q, clock_select_q};

   // Sampled in the address phase so the data stands through the data phase
   // Read multiplexer, unmapped reads zero
   assign rd_value = (haddr == capture_timer_pkg::ADDR_CONTROL)         ? ctrl_value :
                     (haddr == capture_timer_pkg::ADDR_CAPTURE_VALUE_F) ? capture_value_f_q :
                     (haddr == capture_timer_pkg::ADDR_CAPTURE_VALUE_R) ? capture_value_r_q :
                     (haddr == capture_timer_pkg::ADDR_COUNT)           ? capture_timer_count_q :
                     8'h00;

   // Counter events
   // The pin is taken as synchronous, so one flop of history gives the edges
   assign wrap = count_tick & (capture_timer_count_q == capture_timer_pkg::COUNT_MAX);
   assign rise = capture_in & ~capture_prev_q;
   assign fall = ~capture_in & capture_prev_q;
   assign clear_cnt = ((counter_clear_select_q == capture_timer_pkg::CLEAR_FALL) & fall) |
                      ((counter_clear_select_q == capture_timer_pkg::CLEAR_RISE) & rise) |
                      ((counter_clear_select_q == capture_timer_pkg::CLEAR_BOTH) & (rise | fall));

   // Zero write clears only after the flag was read as one
   // Writing one to a flag bit has no effect at all
   assign clr_high = wr_ctrl & ~hwdata[capture_timer_pkg::BIT_OVF_HIGH] & seen_high_q;
   assign clr_low  = wr_ctrl & ~hwdata[capture_timer_pkg::BIT_OVF_LOW] & seen_low_q;

   // ***************************************************
   // Outputs
   // ***************************************************
   // Zero wait states and an OKAY response on every transfer
   assign hrdata       = hrdata_q;
   assign hreadyout    = 1'b1;
   assign hresp        = 1'b0;
   assign overflow_irq = overflow_irq_q;

   // ***************************************************
   // Prescaler
   // ***************************************************
   // Tick source; a new clock select takes effect from the next edge
   // The divider runs free, so the first tick after a change may come early
   capture_prescaler u_prescaler (
      .core_clk      (core_clk),
      .rst           (rst),
      .clock_select  (clock_select_q),
      .subclock_tick (subclock_tick),
      .count_tick    (count_tick)
   );

   // ***************************************************
   // Bus phases
   // ***************************************************
   // Bus address and read data phases
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wr_pend_q <= 1'b0;
         addr_q    <= 12'h000;
         hrdata_q  <= 32'h0000_0000;
      end else begin
         wr_pend_q <= access & hwrite;
         if (access) begin
            addr_q <= haddr;
         end
         if (access & ~hwrite) begin
            hrdata_q <= {24'h00_0000, rd_value};
         end
      end
   end

   // ***************************************************
   // Control register
   // ***************************************************
   // Control fields written by software
   always_ff @(posedge core_clk) begin
      if (rst) begin
         overflow_irq_enable_q     <= capture_timer_pkg::RESET_CONTROL[capture_timer_pkg::BIT_OVF_IRQ_EN];
         capture_irq_edge_select_q <= capture_timer_pkg::RESET_CONTROL[capture_timer_pkg::BIT_EDGE_SELECT];
         counter_clear_select_q    <= capture_timer_pkg::RESET_CONTROL[capture_timer_pkg::POS_CLEAR_SEL +: 2];
         clock_select_q            <= capture_timer_pkg::RESET_CONTROL[capture_timer_pkg::POS_CLOCK_SEL +: 2];
      end else if (wr_ctrl) begin
         overflow_irq_enable_q     <= hwdata[capture_timer_pkg::BIT_OVF_IRQ_EN];
         capture_irq_edge_select_q <= hwdata[capture_timer_pkg::BIT_EDGE_SELECT];
         counter_clear_select_q    <= hwdata[capture_timer_pkg::POS_CLEAR_SEL +: 2];
         clock_select_q            <= hwdata[capture_timer_pkg::POS_CLOCK_SEL +: 2];
      end
   end

   // ***************************************************
   // Overflow flags
   // ***************************************************
   // Overflow flags, wrap wins over clear
   // A wrap in the cycle of a clearing write keeps the flag, so no overflow is lost
   // A zero write from software that never saw the flag set leaves it alone
   always_ff @(posedge core_clk) begin
      if (rst) begin
         overflow_flag_high_q <= 1'b0;
         overflow_flag_low_q  <= 1'b0;
         seen_high_q          <= 1'b0;
         seen_low_q           <= 1'b0;
      end else begin
         overflow_flag_high_q <= wrap | (overflow_flag_high_q & ~clr_high);
         overflow_flag_low_q  <= wrap | (overflow_flag_low_q & ~clr_low);
         if (rd_ctrl & overflow_flag_high_q) begin
            seen_high_q <= 1'b1;
         end else if (clr_high) begin
            seen_high_q <= 1'b0;
         end
         if (rd_ctrl & overflow_flag_low_q) begin
            seen_low_q <= 1'b1;
         end else if (clr_low) begin
            seen_low_q <= 1'b0;
         end
      end
   end

   // ***************************************************
   // Counter and capture
   // ***************************************************
   // Counter, capture registers and interrupt request
   // Captures take the count before a clear on the same edge lands
   // The edge history resets to the idle low pin level, so reset gives no false edge
   always_ff @(posedge core_clk) begin
      if (rst) begin
         capture_timer_count_q <= 8'h00;
         capture_value_f_q     <= capture_timer_pkg::RESET_CAPTURE;
         capture_value_r_q     <= capture_timer_pkg::RESET_CAPTURE;
         capture_prev_q        <= 1'b0;
         overflow_irq_q        <= 1'b0;
      end else begin
         capture_prev_q <= capture_in;
         if (fall) begin
            capture_value_f_q <= capture_timer_count_q;
         end
         if (rise) begin
            capture_value_r_q <= capture_timer_count_q;
         end
         if (clear_cnt) begin
            capture_timer_count_q <= 8'h00;
         end else if (count_tick) begin
            capture_timer_count_q <= capture_timer_count_q + 8'h01;
         end
         // One-cycle request; a disabled overflow still sets both flags
         overflow_irq_q <= wrap & overflow_irq_enable_q;
      end
   end

endmodule : input_capture_timer_8bit

// [dv/capture_timer_sva.sv]
// Port checker for the capture timer
`timescale 1ns/1ps
module capture_timer_sva (
   // Clock, reset, bus and interrupt
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        overflow_irq
);
   localparam logic [11:0] CTL = capture_timer_pkg::ADDR_CONTROL;
   // *****************
   // Shadow state
   // *****************
   wire        take = hsel & hready & (htrans == capture_timer_pkg::HTRANS_NONSEQ);
   logic       wr_q;
   logic       en_q;
   logic [9:0] gap_q;
   // Track the enable bit and the cycles since the last interrupt
   always_ff @(posedge core_clk) begin
      wr_q  <= rst ? 1'b0 : take & hwrite & (haddr == CTL);
      en_q  <= rst ? 1'b0 : (wr_q ? hwdata[capture_timer_pkg::BIT_OVF_IRQ_EN] : en_q);
      gap_q <= (rst | overflow_irq) ? 10'h000 : gap_q + {9'h000, ~&gap_q};
   end
   AST_OKAY: assert property (@(posedge core_clk) disable iff (rst) hreadyout && !hresp)
      else $error("slave not ready or not okay");
   AST_UPPER_ZERO: assert property (@(posedge core_clk) disable iff (rst) hrdata[31:8] == 24'h000000)
      else $error("upper read data not zero");
   AST_RESET_CLEAR: assert property (@(posedge core_clk) rst |=> hrdata == 32'h0 && !overflow_irq)
      else $error("reset did not clear outputs");
   AST_HOLD: assert property (@(posedge core_clk) disable iff (rst) !(take & !hwrite) |=> $stable(hrdata))
      else $error("read data changed without a read");
   AST_IRQ_PULSE: assert property (@(posedge core_clk) disable iff (rst) overflow_irq |=> !overflow_irq)
      else $error("interrupt longer than one cycle");
   AST_IRQ_GATED: assert property (@(posedge core_clk) disable iff (rst) overflow_irq |-> en_q || $past(en_q))
      else $error("interrupt while disabled");
   AST_IRQ_SPACING: assert property (@(posedge core_clk) disable iff (rst) overflow_irq |-> gap_q >= 10'h0FF)
      else $error("interrupts closer than a full count");
   AST_EN_READ: assert property (@(posedge core_clk) disable iff (rst)
      (take && !hwrite && haddr == CTL) |=> hrdata[5] == $past(en_q)) else $error("enable bit read wrong");
endmodule : capture_timer_sva
bind input_capture_timer_8bit capture_timer_sva u_sva (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
   .hwdata, .hready, .hrdata, .hreadyout, .hresp, .overflow_irq);

// [dv/capture_source.sv]
// Capture pin and subclock source model
`timescale 1ns/1ps
module capture_source #(parameter int SUB_PERIOD = 4, parameter int DELAY = 2) (
   // Clock and level request
   input wire logic core_clk,
   input wire logic level_req,
   // Pins toward the timer
   output logic     capture_in = 1'b0,
   output logic     subclock_tick = 1'b0
);
   logic [7:0] dly_q = 8'h00;
   int         ph_q = 0;
   // Pin follows the request after a lag; subclock pulses periodically
   always @(posedge core_clk) begin
      dly_q <= {dly_q[6:0], level_req};
      ph_q <= (ph_q == SUB_PERIOD - 1) ? 0 : ph_q + 1;
      capture_in <= dly_q[DELAY-1];
      subclock_tick <= (ph_q == 0);
   end
endmodule : capture_source

// [dv/input_capture_timer_8bit_tb.sv]
// Self-checking bench for the capture timer
`timescale 1ns/1ps
module input_capture_timer_8bit_tb;
   localparam logic [11:0] A_CTL = capture_timer_pkg::ADDR_CONTROL;
   localparam logic [11:0] A_F = capture_timer_pkg::ADDR_CAPTURE_VALUE_F;
   localparam logic [11:0] A_R = capture_timer_pkg::ADDR_CAPTURE_VALUE_R;
   localparam logic [11:0] A_CNT = capture_timer_pkg::ADDR_COUNT;
   logic        core_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, level_req = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0, hrdata, rv;
   logic        hreadyout, hresp, capture_in, subclock_tick, overflow_irq;
   int          n_mismatch = 0, check_count = 0, n_irq = 0, n, c;
   int          per[4] = '{64, 32, 2, 8};
   logic [31:0] wv[4] = '{32'h22, 32'hA2, 32'h62, 32'hE2};
   logic [31:0] ev[4] = '{32'hE2, 32'hA2, 32'h22, 32'h22};
   always #25 core_clk = ~core_clk;
   capture_source u_src (.core_clk, .level_req, .capture_in, .subclock_tick);
   input_capture_timer_8bit dut (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .capture_in, .subclock_tick, .overflow_irq);
   // Count interrupt pulses
   always @(posedge core_clk) if (overflow_irq === 1'b1) n_irq++;
   // *****************
   // Tasks
   // *****************
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= capture_timer_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask : xfer
   // Watchdog
   initial begin
      #1000000;
      n_mismatch++;
      conclude();
   end
   // Main sequence
   initial begin
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      xfer(1, A_F, 32'hFF);
      xfer(1, A_R, 32'hFF);
      xfer(0, A_CTL, 0);
      check("control reset", rv, 32'h0);
      xfer(0, A_F, 0);
      check("capture f", rv, 32'h0);
      xfer(0, A_R, 0);
      check("capture r", rv, 32'h0);
      xfer(0, 12'h004, 0);
      check("unmapped", rv, 32'h0);
      xfer(1, A_CTL, 32'h3F);
      xfer(0, A_CTL, 0);
      check("control fields", rv, 32'h3F);
      for (int k = 0; k < 4; k++) begin
         xfer(1, A_CTL, k);
         xfer(0, A_CNT, 0);
         c = rv;
         repeat (254) @(posedge core_clk);
         xfer(0, A_CNT, 0);
         check("count rate", (rv - c) & 32'hFF, 256 / per[k]);
      end
      xfer(1, A_CTL, 32'h22);
      n = 0;
      while (overflow_irq !== 1'b1 && n < 700) begin
         @(posedge core_clk);
         n++;
      end
      check("irq raised", n < 700, 1);
      foreach (wv[i]) begin
         xfer(1, A_CTL, wv[i]);
         xfer(0, A_CTL, 0);
         check("overflow flags", rv, ev[i]);
      end
      xfer(1, A_CTL, 32'h02);
      n = n_irq;
      repeat (600) @(posedge core_clk);
      check("irq masked", n_irq, n);
      xfer(0, A_CTL, 0);
      check("flags while masked", rv, 32'hC2);
      for (int m = 0; m < 4; m++) begin
         for (int e = 1; e >= 0; e--) begin
            xfer(1, A_CTL, (m << 2) | 2);
            do xfer(0, A_CNT, 0); while (rv < 32 || rv > 200);
            c = rv;
            level_req <= e[0];
            repeat (6) @(posedge core_clk);
            xfer(0, A_CNT, 0);
            check("clear on edge", rv < c, e ? m[1] : m[0]);
            if (m == 0) begin
               xfer(0, e ? A_R : A_F, 0);
               check("captured count", (rv - c) < 8, 1);
            end
         end
      end
      // Reset in mid-run clears the captures and the control register
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      xfer(0, A_R, 0);
      check("capture r after reset", rv, 32'h0);
      xfer(0, A_F, 0);
      check("capture f after reset", rv, 32'h0);
      xfer(0, A_CTL, 0);
      check("control after reset", rv, 32'h0);
      conclude();
   end
endmodule : input_capture_timer_8bit_tb
